// >>> instrument_status_reporting_tb.sv
// Purpose: self-checking bench of the status reporting block
// Assumes: 25 MHz clock, inputs driven on the falling edge
// Notes:   expected reply bytes queue up and are popped per byte
`timescale 1ns/1ns
module instrument_status_reporting_tb
	import isr_pkg::*;
;
	//------------------------------------------------------------
	// Signals and instances
	//------------------------------------------------------------
	logic core_clk = 0, nrst = 0, cmd_valid = 0, cmd_src = 0, slow = 0;
	logic quench_pin = 0, rampdown_pin = 0, nv_psc = 1;
	isr_cmd_t cmd_op = ISR_CMD_STB_Q;
	logic [7:0] cmd_arg = 8'h00, nv_sre = 8'h00, nv_ese = 8'h00, s = 8'h36, v;
	logic [5:0] pv = 6'h00;
	logic cmd_ready, rep_valid, rep_ready, rep_dst, rep_last, serial_unread;
	logic psc_store, quench_flag;
	logic [7:0] rep_data, sre_store, ese_store, standard_event_latch;
	logic [7:0] exp_q[$];
	int errors = 0, cmp_count = 0, cyc = 0;

	always #20 core_clk = ~core_clk;

	isr_status isr_status_inst (.core_clk(core_clk), .nrst(nrst), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_arg(cmd_arg), .cmd_src(cmd_src),
		.rep_valid(rep_valid), .rep_ready(rep_ready), .rep_data(rep_data), .rep_dst(rep_dst),
		.rep_last(rep_last), .err_command(pv[0]), .err_execution(pv[1]), .err_query(pv[2]),
		.err_device(pv[3]), .quench_pin(quench_pin), .rampdown_pin(rampdown_pin),
		.quench_clear(pv[4]), .serial_unread(serial_unread), .nv_psc(nv_psc), .nv_sre(nv_sre),
		.nv_ese(nv_ese), .psc_store(psc_store), .sre_store(sre_store), .ese_store(ese_store),
		.standard_event_latch(standard_event_latch), .quench_flag(quench_flag));
	isr_host_model isr_host_model_inst (.core_clk(core_clk), .nrst(nrst), .rep_valid(rep_valid),
		.rep_dst(rep_dst), .slow(slow), .flush(pv[5]), .rep_ready(rep_ready),
		.serial_unread(serial_unread));

	function automatic logic [7:0] lfsr(logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : lfsr

	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic idle(int n);
		repeat (n) @(negedge core_clk);
	endtask : idle

	task automatic pulse(int k);
		@(negedge core_clk);
		pv[k] = 1'b1;
		@(negedge core_clk);
		pv[k] = 1'b0;
	endtask : pulse

	task automatic rst;
		@(negedge core_clk);
		nrst = 0;
		idle(20);
		nrst = 1;
		idle(2);
	endtask : rst

	// Expectation is noted only once the block is ready, so prior replies have landed
	task automatic cmd(isr_cmd_t op, logic src = 1'b0, int ev = -1, logic [7:0] arg = 8'h00);
		string t;
		int n = 0;
		@(negedge core_clk);
		{cmd_valid, cmd_src, cmd_arg} = {1'b1, src, arg};
		cmd_op = op;
		while (!cmd_ready && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		if (ev >= 0) begin
			t = $sformatf("%0d", ev);
			foreach (t[i]) exp_q.push_back(t[i]);
			exp_q.push_back(ASCII_CR);
			exp_q.push_back(ASCII_LF);
		end
		@(negedge core_clk);
		cmd_valid = 0;
	endtask : cmd

	task automatic finish_test;
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	//------------------------------------------------------------
	// Reply watcher and timeout
	//------------------------------------------------------------
	always @(posedge core_clk) begin
		cyc++;
		if (nrst && rep_valid && rep_ready)
			chk("reply", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rep_data);
		if (cyc == 20000) begin
			errors++;
			finish_test();
		end
	end

	initial begin
		rst();
		chk("event latch", 8'h80, standard_event_latch);
		cmd(ISR_CMD_ESR_Q, 1'b0, 8'h80);
		cmd(ISR_CMD_ESR_Q, 1'b0, 8'h00);
		for (int k = 0; k < 8; k++) pulse(k % 4);
		cmd(ISR_CMD_OPC);
		cmd(ISR_CMD_ESR_Q, 1'b0, 8'h3d);
		for (int k = 0; k < 4; k++) begin
			s = lfsr(s);
			v = s & ESR_USED;
			cmd(ISR_CMD_ESE_W, 1'b0, -1, v);
			cmd(ISR_CMD_ESE_Q, 1'b0, v);
		end
		cmd(ISR_CMD_SRE_W, 1'b0, -1, 8'h20);
		cmd(ISR_CMD_SRE_Q, 1'b0, 8'h20);
		pulse(3);
		cmd(ISR_CMD_CLS);
		chk("event latch", 8'h00, standard_event_latch);
		cmd(ISR_CMD_ESE_Q, 1'b0, v);
		cmd(ISR_CMD_ESE_W, 1'b0, -1, 8'h20);
		pulse(0);
		idle(8);
		pulse(5);
		cmd(ISR_CMD_STB_Q, 1'b1, 8'h60);
		cmd(ISR_CMD_STB_Q, 1'b1, 8'h60);
		cmd(ISR_CMD_ESR_Q, 1'b0, 8'h20);
		cmd(ISR_CMD_STB_Q, 1'b1, 8'h08);
		idle(8);
		pulse(5);
		cmd(ISR_CMD_STB_Q, 1'b1, 8'h00);
		rampdown_pin = 1;
		idle(6);
		cmd(ISR_CMD_STB_Q, 1'b1, 8'h02);
		quench_pin = 1;
		idle(6);
		quench_pin = 0;
		idle(6);
		cmd(ISR_CMD_STB_Q, 1'b1, 8'h06);
		chk("quench", 8'h01, {7'h00, quench_flag});
		pulse(4);
		idle(4);
		chk("quench", 8'h00, {7'h00, quench_flag});
		rampdown_pin = 0;
		idle(6);
		// Rampdown bit must drop with its condition
		cmd(ISR_CMD_STB_Q, 1'b1, 8'h00);
		slow = 1;
		cmd(ISR_CMD_OPC_Q, 1'b0, 8'h01);
		cmd(ISR_CMD_ESE_Q, 1'b0, 8'h20);
		cmd(ISR_CMD_ESE_W);
		cmd(ISR_CMD_ESE_Q, 1'b0, 8'h00);
		cmd(ISR_CMD_PSC_W);
		idle(30);
		slow = 0;
		chk("psc", 8'h00, {7'h00, psc_store});
		{nv_psc, nv_ese, nv_sre} = {1'b0, 8'h11, 8'h22};
		rst();
		cmd(ISR_CMD_ESE_Q, 1'b0, 8'h11);
		cmd(ISR_CMD_SRE_Q, 1'b0, 8'h22);
		cmd(ISR_CMD_PSC_Q, 1'b0, 8'h00);
		idle(10);
		nv_psc = 1;
		rst();
		cmd(ISR_CMD_ESE_Q, 1'b0, 8'h00);
		chk("event latch", 8'h80, standard_event_latch);
		idle(10);
		chk("pending", 8'h00, 8'(exp_q.size()));
		finish_test();
	end
endmodule : instrument_status_reporting_tb

bind isr_status isr_status_monitor isr_status_monitor_inst (.core_clk(core_clk), .nrst(nrst),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .rep_valid(rep_valid),
	.rep_ready(rep_ready), .rep_data(rep_data), .rep_last(rep_last), .err_command(err_command),
	.err_execution(err_execution), .err_query(err_query), .err_device(err_device),
	.quench_clear(quench_clear), .sre_store(sre_store), .ese_store(ese_store),
	.standard_event_latch(standard_event_latch), .quench_flag(quench_flag));

// >>> isr_dec_fmt.sv
//------------------------------------------------------------
// Decimal formatter
//------------------------------------------------------------
// Purpose: turn an 8-bit value into left-aligned ASCII decimal digits
// Assumes: value 0..255, no leading zeros, at least one digit
// Notes:   purely combinational, constant divisors only
`timescale 1ns/1ns
module isr_dec_fmt
	import isr_pkg::*;
(
	input  wire logic [7:0] value,
	output logic      [7:0] char0,
	output logic      [7:0] char1,
	output logic      [7:0] char2,
	output logic      [1:0] ndig
);

	logic [7:0] hund;
	logic [7:0] tens;
	logic [7:0] ones;

	always_comb begin
		hund = value / 8'd100;
		tens = (value / 8'd10) % 8'd10;
		ones = value % 8'd10;
		if (hund != 8'h00) begin
			char0 = ASCII_ZERO + hund;
			char1 = ASCII_ZERO + tens;
			char2 = ASCII_ZERO + ones;
			ndig  = 2'h3;
		end else if (tens != 8'h00) begin
			char0 = ASCII_ZERO + tens;
			char1 = ASCII_ZERO + ones;
			char2 = ASCII_ZERO;
			ndig  = 2'h2;
		end else begin
			char0 = ASCII_ZERO + ones;
			char1 = ASCII_ZERO;
			char2 = ASCII_ZERO;
			ndig  = 2'h1;
		end
	end

endmodule : isr_dec_fmt

// >>> isr_host_model.sv
// Purpose: host side taking reply bytes and reading the serial buffer
// Assumes: slow selects a stalling host
// Notes:   flush stands for the host reading all serial data
`timescale 1ns/1ns
module isr_host_model (
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic rep_valid,
	input  wire logic rep_dst,
	input  wire logic slow,
	input  wire logic flush,
	output logic      rep_ready,
	output logic      serial_unread
);
	//------------------------------------------------------------
	// Output buffer and stalls
	//------------------------------------------------------------
	logic [7:0] held = 8'h00;
	logic [1:0] ph = 2'h0;
	// Slow host takes one byte in three
	always @(negedge core_clk) begin
		ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
		rep_ready <= !slow || ph == 2'h0;
	end
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst || flush)
			held <= 8'h00;
		else if (rep_valid && rep_ready && !rep_dst)
			held <= held + 8'h01;
	end
	assign serial_unread = held != 8'h00;
endmodule : isr_host_model

// >>> isr_pkg.sv
//------------------------------------------------------------
// Status reporting package
//------------------------------------------------------------
// Purpose: shared constants and types of the status reporting block
// Assumes: 8-bit status byte, 8-bit standard-event latch
// Notes:   bit positions, reset values and command codes live here
package isr_pkg;

	//------------------------------------------------------------
	// Status byte bit positions
	//------------------------------------------------------------
	localparam int STB_RAMPDOWN = 1;
	localparam int STB_QUENCH   = 2;
	localparam int STB_SER_MAV  = 3;
	localparam int STB_ESB      = 5;
	localparam int STB_RQS      = 6;

	//------------------------------------------------------------
	// Standard-event bit positions
	//------------------------------------------------------------
	localparam int ESR_OPC   = 0;
	localparam int ESR_QUERY = 2;
	localparam int ESR_DEV   = 3;
	localparam int ESR_EXEC  = 4;
	localparam int ESR_CMD   = 5;
	localparam int ESR_PON   = 7;

	//------------------------------------------------------------
	// Reset values and fixed masks
	//------------------------------------------------------------
	localparam logic [7:0] ESR_RESET    = 8'h80;
	localparam logic [7:0] ESR_USED     = 8'hbd;
	localparam logic [7:0] STB_USED     = 8'h6e;
	localparam logic [7:0] MASK_RESET   = 8'h00;
	localparam logic       PSC_RESET    = 1'b1;
	localparam logic [7:0] ASCII_ZERO   = 8'h30;
	localparam logic [7:0] ASCII_CR     = 8'h0d;
	localparam logic [7:0] ASCII_LF     = 8'h0a;
	localparam logic [7:0] OPC_REPLY    = 8'h01;
	localparam int         SYNC_STAGES  = 3;
	localparam int         REPLY_MAX    = 5;

	//------------------------------------------------------------
	// Commands handed over by the command queue
	//------------------------------------------------------------
	typedef enum logic [3:0] {
		ISR_CMD_STB_Q = 4'h0,
		ISR_CMD_SRE_W = 4'h1,
		ISR_CMD_SRE_Q = 4'h2,
		ISR_CMD_CLS   = 4'h3,
		ISR_CMD_ESR_Q = 4'h4,
		ISR_CMD_ESE_W = 4'h5,
		ISR_CMD_ESE_Q = 4'h6,
		ISR_CMD_PSC_W = 4'h7,
		ISR_CMD_PSC_Q = 4'h8,
		ISR_CMD_OPC   = 4'h9,
		ISR_CMD_OPC_Q = 4'ha
	} isr_cmd_t;

	typedef enum logic [1:0] {
		ISR_RP_INIT = 2'b00,
		ISR_RP_IDLE = 2'b01,
		ISR_RP_SEND = 2'b11
	} isr_rp_state_t;

endpackage : isr_pkg

// >>> isr_status.sv
//------------------------------------------------------------
// Instrument status reporting
//------------------------------------------------------------
// Purpose: status byte, standard-event latch, enable masks, replies
// Assumes: commands arrive in queue order, one per accepted handshake
// Notes:   nrst is the power cycle; masks survive it through nv_* ports while nv_psc is clear
//
// Behaviour
// - Condition bits 1,3 follow live state, read-only
// - Event bit latches once, repeats ignored
// - Event bit holds until query or clear
// - Queries reply with decimal weighted sum
// - Masks writable, readable, untouched by clear-status
// - Serial message bit 3 follows unread data
// - Message bit clears once buffer drained
// - Clearing events recomputes summary bit 5
// - Bit 1 is rampdown; 0,4,7 read zero
// - Bit 2 latches quench until cleared
// - Bit 5 set by any enabled event
// - Bit 6 set by any enabled status bit
// - Status byte clears; event read clears bit5
// - Status query in order, bit 6 kept
// - Masks clear on zero; power-up per setting
// - Event latch clears on clear, read, power
// - Bit 0 on operation complete; 1,6 zero
// - Bits 2,3 latch query, device errors
// - Bits 4,5 latch execution, command errors
// - Bit 7 set at power-up until cleared
// - Completion query replies 1 plus CR LF
`timescale 1ns/1ns
module isr_status
	import isr_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	// Command queue side
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire isr_cmd_t   cmd_op,
	input  wire logic [7:0] cmd_arg,
	input  wire logic       cmd_src,
	// Reply bytes towards the output buffers
	output logic            rep_valid,
	input  wire logic       rep_ready,
	output logic      [7:0] rep_data,
	output logic            rep_dst,
	output logic            rep_last,
	// Error reporting, one-cycle pulses from the parser
	input  wire logic       err_command,
	input  wire logic       err_execution,
	input  wire logic       err_query,
	input  wire logic       err_device,
	// Instrument conditions
	input  wire logic       quench_pin,
	input  wire logic       rampdown_pin,
	input  wire logic       quench_clear,
	input  wire logic       serial_unread,
	// Non-volatile settings
	input  wire logic       nv_psc,
	input  wire logic [7:0] nv_sre,
	input  wire logic [7:0] nv_ese,
	output logic            psc_store,
	output logic      [7:0] sre_store,
	output logic      [7:0] ese_store,
	// Observation
	output logic      [7:0] standard_event_latch,
	output logic            quench_flag
);

	//------------------------------------------------------------
	// Pin synchronisers
	//------------------------------------------------------------
	logic [1:0] pin_raw;
	logic [1:0] pin_live;

	assign pin_raw = {rampdown_pin, quench_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			logic [SYNC_STAGES-1:0] stage;
			logic                   level;

			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					stage <= '0;
				end else begin
					stage <= {stage[SYNC_STAGES-2:0], pin_raw[gi]};
				end
			end

			// Only the last two stages vote; the first is metastable
			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					level <= 1'b0;
				end else if (stage[1] == stage[2]) begin
					level <= stage[2];
				end
			end

			assign pin_live[gi] = level;
		end
	endgenerate

	//------------------------------------------------------------
	// Command decode
	//------------------------------------------------------------
	isr_rp_state_t rp_state;
	logic          cmd_take;
	logic          do_cls;
	logic          do_esr_read;

	assign cmd_ready   = (rp_state == ISR_RP_IDLE);
	assign cmd_take    = cmd_valid && cmd_ready;
	assign do_cls      = cmd_take && (cmd_op == ISR_CMD_CLS);
	assign do_esr_read = cmd_take && (cmd_op == ISR_CMD_ESR_Q);

	//------------------------------------------------------------
	// Quench latch
	//------------------------------------------------------------
	// A fresh detection wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			quench_flag <= 1'b0;
		end else if (pin_live[0]) begin
			quench_flag <= 1'b1;
		end else if (quench_clear) begin
			quench_flag <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// Standard-event latch
	//------------------------------------------------------------
	logic [7:0] esr_set;
	logic [7:0] next_esr;

	always_comb begin
		esr_set            = 8'h00;
		esr_set[ESR_OPC]   = cmd_take && (cmd_op == ISR_CMD_OPC);
		esr_set[ESR_QUERY] = err_query;
		esr_set[ESR_DEV]   = err_device;
		esr_set[ESR_EXEC]  = err_execution;
		esr_set[ESR_CMD]   = err_command;
		// Events in the clearing cycle survive the clear
		if (do_cls || do_esr_read) begin
			next_esr = esr_set & ESR_USED;
		end else begin
			next_esr = (standard_event_latch | esr_set) & ESR_USED;
		end
	end

	// Power cycle leaves only the power-on bit
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			standard_event_latch <= ESR_RESET;
		end else begin
			standard_event_latch <= next_esr;
		end
	end

	//------------------------------------------------------------
	// Enable masks and power-on clear setting
	//------------------------------------------------------------
	logic pwr_init;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pwr_init <= 1'b1;
		end else begin
			pwr_init <= 1'b0;
		end
	end

	// Masks are reloaded from storage, or cleared if nv_psc is set, one cycle after release
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			psc_store <= PSC_RESET;
		end else if (pwr_init) begin
			psc_store <= nv_psc;
		end else if (cmd_take && (cmd_op == ISR_CMD_PSC_W)) begin
			psc_store <= (cmd_arg != 8'h00);
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sre_store <= MASK_RESET;
		end else if (pwr_init) begin
			sre_store <= nv_psc ? MASK_RESET : (nv_sre & STB_USED);
		end else if (cmd_take && (cmd_op == ISR_CMD_SRE_W)) begin
			sre_store <= cmd_arg & STB_USED;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ese_store <= MASK_RESET;
		end else if (pwr_init) begin
			ese_store <= nv_psc ? MASK_RESET : (nv_ese & ESR_USED);
		end else if (cmd_take && (cmd_op == ISR_CMD_ESE_W)) begin
			ese_store <= cmd_arg & ESR_USED;
		end
	end

	//------------------------------------------------------------
	// Status byte
	//------------------------------------------------------------
	// Live from conditions and registers, so no stale summary can be read
	logic [7:0] stb_low;
	logic [7:0] status_summary_byte;

	always_comb begin
		stb_low               = 8'h00;
		stb_low[STB_RAMPDOWN] = pin_live[1];
		stb_low[STB_QUENCH]   = quench_flag;
		stb_low[STB_SER_MAV]  = serial_unread;
		stb_low[STB_ESB]      = |(standard_event_latch & ese_store);
		status_summary_byte   = stb_low;
		status_summary_byte[STB_RQS] = |(stb_low & sre_store);
		status_summary_byte   = status_summary_byte & STB_USED;
	end

	//------------------------------------------------------------
	// Reply value selection and formatting
	//------------------------------------------------------------
	logic       is_query;
	logic [7:0] query_value;
	logic [7:0] fmt_c0;
	logic [7:0] fmt_c1;
	logic [7:0] fmt_c2;
	logic [1:0] fmt_n;

	always_comb begin
		is_query    = 1'b1;
		query_value = 8'h00;
		case (cmd_op)
			ISR_CMD_STB_Q: query_value = status_summary_byte;
			ISR_CMD_SRE_Q: query_value = sre_store;
			ISR_CMD_ESR_Q: query_value = standard_event_latch;
			ISR_CMD_ESE_Q: query_value = ese_store;
			ISR_CMD_PSC_Q: query_value = {7'h00, psc_store};
			ISR_CMD_OPC_Q: query_value = OPC_REPLY;
			default:       is_query    = 1'b0;
		endcase
	end

	isr_dec_fmt u_fmt (
		.value (query_value),
		.char0 (fmt_c0),
		.char1 (fmt_c1),
		.char2 (fmt_c2),
		.ndig  (fmt_n)
	);

	//------------------------------------------------------------
	// Reply sender
	//------------------------------------------------------------
	logic [7:0] rep_buf [REPLY_MAX];
	logic [2:0] rep_len;
	logic [2:0] rep_idx;

	// The reply is frozen at accept time, so later events cannot tear it
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < REPLY_MAX; i++) begin
				rep_buf[i] <= 8'h00;
			end
			rep_len <= 3'h0;
			rep_dst <= 1'b0;
		end else if (cmd_take && is_query) begin
			rep_buf[0] <= fmt_c0;
			rep_buf[1] <= (fmt_n == 2'h1) ? ASCII_CR : fmt_c1;
			rep_buf[2] <= (fmt_n == 2'h1) ? ASCII_LF : (fmt_n == 2'h2) ? ASCII_CR : fmt_c2;
			rep_buf[3] <= (fmt_n == 2'h2) ? ASCII_LF : ASCII_CR;
			rep_buf[4] <= ASCII_LF;
			rep_len    <= {1'b0, fmt_n} + 3'h2;
			rep_dst    <= cmd_src;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rp_state <= ISR_RP_INIT;
		end else begin
			case (rp_state)
				ISR_RP_INIT: rp_state <= ISR_RP_IDLE;
				ISR_RP_IDLE: begin
					if (cmd_take && is_query) begin
						rp_state <= ISR_RP_SEND;
					end
				end
				ISR_RP_SEND: begin
					if (rep_ready && (rep_idx == rep_len - 3'h1)) begin
						rp_state <= ISR_RP_IDLE;
					end
				end
				default: rp_state <= ISR_RP_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rep_idx <= 3'h0;
		end else if (rp_state != ISR_RP_SEND) begin
			rep_idx <= 3'h0;
		end else if (rep_ready) begin
			rep_idx <= rep_idx + 3'h1;
		end
	end

	assign rep_valid = (rp_state == ISR_RP_SEND);
	assign rep_data  = rep_buf[rep_idx];
	assign rep_last  = rep_valid && (rep_idx == rep_len - 3'h1);

endmodule : isr_status

// >>> isr_status_monitor.sv
// Purpose: port checker for the status reporting block
// Assumes: one clock, nrst asynchronous and active low
// Notes:   bound to isr_status from the testbench top
`timescale 1ns/1ns
module isr_status_monitor
	import isr_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       nrst,
	input wire logic       cmd_valid,
	input wire logic       cmd_ready,
	input wire isr_cmd_t   cmd_op,
	input wire logic       rep_valid,
	input wire logic       rep_ready,
	input wire logic [7:0] rep_data,
	input wire logic       rep_last,
	input wire logic       err_command,
	input wire logic       err_execution,
	input wire logic       err_query,
	input wire logic       err_device,
	input wire logic       quench_clear,
	input wire logic [7:0] sre_store,
	input wire logic [7:0] ese_store,
	input wire logic [7:0] standard_event_latch,
	input wire logic       quench_flag
);
	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic tk;
	logic noerr;
	assign tk = cmd_valid && cmd_ready;
	// Error arriving with a clear would legally survive it
	assign noerr = !(err_command || err_execution || err_query || err_device);

	reply_hold_a: assert property (rep_valid && !rep_ready |=> rep_valid && $stable(rep_data))
		else $error("reply byte changed while stalled");
	busy_refuse_a: assert property (rep_valid |-> !cmd_ready)
		else $error("command accepted during reply");
	read_clear_a: assert property (tk && cmd_op == ISR_CMD_ESR_Q && noerr |=> standard_event_latch == 8'h00)
		else $error("event latch kept bits after read");
	cls_clear_a: assert property (tk && cmd_op == ISR_CMD_CLS && noerr |=> standard_event_latch == 8'h00)
		else $error("event latch kept bits after clear");
	cls_masks_a: assert property (tk && cmd_op == ISR_CMD_CLS |=> $stable(ese_store) && $stable(sre_store))
		else $error("clear status touched a mask");
	query_err_a: assert property (err_query |=> standard_event_latch[ESR_QUERY])
		else $error("query error not latched");
	event_hold_a: assert property (!(tk && (cmd_op == ISR_CMD_CLS || cmd_op == ISR_CMD_ESR_Q))
		|=> (standard_event_latch & $past(standard_event_latch)) == $past(standard_event_latch))
		else $error("event bit dropped without clear");
	unused_zero_a: assert property ((standard_event_latch & ~ESR_USED) == 8'h00)
		else $error("unused event bit set");
	quench_hold_a: assert property (quench_flag && !quench_clear |=> quench_flag)
		else $error("quench flag dropped without clear");
	reply_end_a: assert property (rep_valid && rep_last |-> rep_data == ASCII_LF)
		else $error("reply not ended by line feed");

	cover property (tk && cmd_op == ISR_CMD_ESR_Q);
	cover property (rep_valid && !rep_ready);
	cover property ($rose(quench_flag));
endmodule : isr_status_monitor
